/* rtl/cis_defines.svh */
// Register addresses, field positions and code constants for comparator input selection
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH

// Special-function register page and addresses
`define CIS_SFR_PAGE 8'h00
`define CIS_ADDR_COMP1_SEL 8'h9e
`define CIS_ADDR_COMP0_SEL 8'h9f

// Reset value of both selection registers
`define CIS_SEL_RESET 8'hff

// Field positions inside a selection register
`define CIS_NEG_MSB 7
`define CIS_NEG_LSB 4
`define CIS_POS_MSB 3
`define CIS_POS_LSB 0

// Codes that map to a defined source (bit n set means code n is defined)
`define CIS_NEG_VALID_MASK 16'hf7cf
`define CIS_POS_VALID_MASK 16'hff8f

// Half-supply code, shared by both polarities
`define CIS_CODE_HALF_SUPPLY 4'hd

// Code held after reset, and its one-hot select vector
`define CIS_CODE_RESET 4'hf
`define CIS_SEL_RESET_ONEHOT 16'h8000

// Value read from an unmapped address
`define CIS_RDATA_IDLE 8'h00

`endif

/* rtl/cis_pkg.sv */
// Types shared by the comparator input select block
package cis_pkg;

    typedef logic [3:0] cis_code_t;
    typedef logic [15:0] cis_sel_t;
    typedef logic [7:0] cis_byte_t;

endpackage

/* rtl/cis_src_decode.sv */
// Decoder from a 4-bit input code to one-hot analog mux select lines
`timescale 1ns/100ps
`default_nettype none
`include "cis_defines.svh"

module cis_src_decode
    import cis_pkg::*;
#(
    parameter cis_sel_t VALID_MASK = `CIS_NEG_VALID_MASK
) (
    // Selection code
    input wire cis_code_t code,
    // Decoded selects
    output logic [15:0] sel,
    output logic half_en
);

    // Reserved codes leave every select low, so no source is connected
    always_comb begin
        sel = '0;
        if (VALID_MASK[code]) begin
            sel[code] = 1'b1;
        end
        half_en = (code == `CIS_CODE_HALF_SUPPLY);
    end

    // Reset parks every mux on code 1111, so a mask that drops it would float the input
    if (!VALID_MASK[`CIS_CODE_RESET]) begin : g_mask_check
        $error("valid mask leaves the reset code without a source");
    end

endmodule
`default_nettype wire

/* rtl/cis_input_select.sv */
// Comparator input selection registers and analog mux select drivers
`timescale 1ns/100ps
`default_nettype none
`include "cis_defines.svh"

module cis_input_select
    import cis_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Special-function register access
    input wire logic [7:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Comparator0 analog mux selects, one-hot by code
    output logic [15:0] comp0_neg_sel,
    output logic [15:0] comp0_pos_sel,
    output logic comp0_half_div_en,
    // Comparator1 analog mux selects, one-hot by code
    output logic [15:0] comp1_neg_sel,
    output logic [15:0] comp1_pos_sel,
    output logic comp1_half_div_en
);

    // How software sees this block:
    //   both registers sit on page 0 and read back exactly what was written;
    //   a write retargets the muxes at the same clock edge on which it lands;
    //   a read answers one cycle later on sfr_rdata, with sfr_hit for one cycle;
    //   an unmapped read answers 0x00 with sfr_hit low, so a poll can tell them apart.
    // Hazard: the select lines move with no break-before-make of their own,
    //   so the analog switch cells must not short two sources while they change.
    // Limitation: nothing here configures the pins themselves; a pin picked as a
    //   source must be set up as an analog input elsewhere.

    // Register state
    cis_byte_t comparator0_input_select_ff;
    cis_byte_t comparator1_input_select_ff;
    cis_byte_t nxt_comparator0_input_select;
    cis_byte_t nxt_comparator1_input_select;
    cis_byte_t sfr_rdata_ff;
    cis_byte_t nxt_sfr_rdata;
    logic sfr_hit_ff;
    logic nxt_sfr_hit;

    // Decoded select state
    cis_sel_t comp0_neg_sel_ff;
    cis_sel_t comp0_pos_sel_ff;
    cis_sel_t comp1_neg_sel_ff;
    cis_sel_t comp1_pos_sel_ff;
    logic comp0_half_ff;
    logic comp1_half_ff;
    cis_sel_t nxt_comp0_neg_sel;
    cis_sel_t nxt_comp0_pos_sel;
    cis_sel_t nxt_comp1_neg_sel;
    cis_sel_t nxt_comp1_pos_sel;
    logic c0n_half;
    logic c0p_half;
    logic c1n_half;
    logic c1p_half;
    logic nxt_comp0_half;
    logic nxt_comp1_half;

    // Field views of the next register values
    cis_code_t comp0_negative_select;
    cis_code_t comp0_positive_select;
    cis_code_t comp1_negative_select;
    cis_code_t comp1_positive_select;
    logic sel0_addr;
    logic sel1_addr;

    // Address decode; only page 0 maps, any other page falls through to no hit
    always_comb begin
        sel0_addr = 1'b0;
        sel1_addr = 1'b0;
        if (sfr_page == `CIS_SFR_PAGE && sfr_addr == `CIS_ADDR_COMP0_SEL) begin
            sel0_addr = 1'b1;
        end else if (sfr_page == `CIS_SFR_PAGE && sfr_addr == `CIS_ADDR_COMP1_SEL) begin
            sel1_addr = 1'b1;
        end
    end

    // Next register values; every bit is stored as written, reserved codes too
    always_comb begin
        nxt_comparator0_input_select = comparator0_input_select_ff;
        nxt_comparator1_input_select = comparator1_input_select_ff;
        if (sfr_wr && sel0_addr) begin
            nxt_comparator0_input_select = sfr_wdata;
        end
        if (sfr_wr && sel1_addr) begin
            nxt_comparator1_input_select = sfr_wdata;
        end
    end

    // Read port; data is captured on the strobe and held until the next read.
    // It looks at the stored byte, so a read in the cycle of a write sees the old one.
    always_comb begin
        nxt_sfr_rdata = sfr_rdata_ff;
        nxt_sfr_hit = 1'b0;
        if (sfr_rd) begin
            nxt_sfr_hit = sel0_addr | sel1_addr;
            if (sel0_addr) begin
                nxt_sfr_rdata = comparator0_input_select_ff;
            end else if (sel1_addr) begin
                nxt_sfr_rdata = comparator1_input_select_ff;
            end else begin
                nxt_sfr_rdata = `CIS_RDATA_IDLE;
            end
        end
    end

    // Nibble split feeds the decoders from the next values, so selects track the register
    always_comb begin
        comp0_negative_select = nxt_comparator0_input_select[`CIS_NEG_MSB:`CIS_NEG_LSB];
        comp0_positive_select = nxt_comparator0_input_select[`CIS_POS_MSB:`CIS_POS_LSB];
        comp1_negative_select = nxt_comparator1_input_select[`CIS_NEG_MSB:`CIS_NEG_LSB];
        comp1_positive_select = nxt_comparator1_input_select[`CIS_POS_MSB:`CIS_POS_LSB];
    end

    // Code map, negative input (upper nibble):
    //   0-3 odd pins of port 0, 6-7 port 1 pins 5 and 7,
    //   8-10 port 2 pins 1, 3 and 5, 12 touch reference,
    //   13 half supply, 14 digital supply, 15 ground; 4, 5 and 11 connect nothing.
    // Code map, positive input (lower nibble):
    //   0-3 even pins of port 0, 7 port 1 pin 6,
    //   8-11 even pins of port 2, 12 touch reference,
    //   13 half supply, 14 battery supply, 15 main supply; 4 to 6 connect nothing.
    // Select bit n drives the analog switch for code n, so the switch array
    // outside this block is wired by code, not by pin name.

    // One decoder per mux; polarity only changes which codes are reserved
    cis_src_decode #(.VALID_MASK(`CIS_NEG_VALID_MASK)) u_c0n (
        .code(comp0_negative_select),
        .sel(nxt_comp0_neg_sel),
        .half_en(c0n_half)
    );
    cis_src_decode #(.VALID_MASK(`CIS_POS_VALID_MASK)) u_c0p (
        .code(comp0_positive_select),
        .sel(nxt_comp0_pos_sel),
        .half_en(c0p_half)
    );
    cis_src_decode #(.VALID_MASK(`CIS_NEG_VALID_MASK)) u_c1n (
        .code(comp1_negative_select),
        .sel(nxt_comp1_neg_sel),
        .half_en(c1n_half)
    );
    cis_src_decode #(.VALID_MASK(`CIS_POS_VALID_MASK)) u_c1p (
        .code(comp1_positive_select),
        .sel(nxt_comp1_pos_sel),
        .half_en(c1p_half)
    );

    // Divider enable per comparator; either input asking for half supply powers it
    always_comb begin
        nxt_comp0_half = c0n_half | c0p_half;
        nxt_comp1_half = c1n_half | c1p_half;
    end

    // Register stage; reset leaves both registers on all ones
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            comparator0_input_select_ff <= `CIS_SEL_RESET;
            comparator1_input_select_ff <= `CIS_SEL_RESET;
        end else begin
            comparator0_input_select_ff <= nxt_comparator0_input_select;
            comparator1_input_select_ff <= nxt_comparator1_input_select;
        end
    end

    // Read port stage; reset clears the answer so no stale byte shows after it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata_ff <= `CIS_RDATA_IDLE;
            sfr_hit_ff <= 1'b0;
        end else begin
            sfr_rdata_ff <= nxt_sfr_rdata;
            sfr_hit_ff <= nxt_sfr_hit;
        end
    end

    // Select stage; reset parks every mux on code 1111 with the divider off.
    // Decoding the next value keeps the selects in step with the register at no latency.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            comp0_neg_sel_ff <= `CIS_SEL_RESET_ONEHOT;
            comp0_pos_sel_ff <= `CIS_SEL_RESET_ONEHOT;
            comp1_neg_sel_ff <= `CIS_SEL_RESET_ONEHOT;
            comp1_pos_sel_ff <= `CIS_SEL_RESET_ONEHOT;
            comp0_half_ff <= 1'b0;
            comp1_half_ff <= 1'b0;
        end else begin
            comp0_neg_sel_ff <= nxt_comp0_neg_sel;
            comp0_pos_sel_ff <= nxt_comp0_pos_sel;
            comp1_neg_sel_ff <= nxt_comp1_neg_sel;
            comp1_pos_sel_ff <= nxt_comp1_pos_sel;
            comp0_half_ff <= nxt_comp0_half;
            comp1_half_ff <= nxt_comp1_half;
        end
    end

    // Outputs straight from flops
    assign sfr_rdata = sfr_rdata_ff;
    assign sfr_hit = sfr_hit_ff;
    assign comp0_neg_sel = comp0_neg_sel_ff;
    assign comp0_pos_sel = comp0_pos_sel_ff;
    assign comp1_neg_sel = comp1_neg_sel_ff;
    assign comp1_pos_sel = comp1_pos_sel_ff;
    assign comp0_half_div_en = comp0_half_ff;
    assign comp1_half_div_en = comp1_half_ff;

endmodule
`default_nettype wire

/* test/cis_input_select_properties.sv */
// Port-level assertions for the comparator input selection block
`timescale 1ns/100ps
`default_nettype none
`include "cis_defines.svh"
module cis_input_select_properties
    import cis_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register access
    input wire logic [7:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Mux selects
    input wire logic [15:0] comp0_neg_sel,
    input wire logic [15:0] comp0_pos_sel,
    input wire logic comp0_half_div_en,
    input wire logic [15:0] comp1_neg_sel,
    input wire logic [15:0] comp1_pos_sel,
    input wire logic comp1_half_div_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Writes that land; another page must leave both registers alone
    sequence s_wr0;
        sfr_wr && sfr_page == 8'h00 && sfr_addr == `CIS_ADDR_COMP0_SEL;
    endsequence
    sequence s_wr1;
        sfr_wr && sfr_page == 8'h00 && sfr_addr == `CIS_ADDR_COMP1_SEL;
    endsequence
    // 0x9e and 0x9f share all but the lowest address bit
    logic map_addr;
    assign map_addr = sfr_page == 8'h00 && sfr_addr[7:1] == 7'h4f;
    a_hit_mapped: assert property (sfr_rd && map_addr |=> sfr_hit) else $error("no hit");
    a_miss_quiet: assert property (sfr_rd && !map_addr
        |=> !sfr_hit && sfr_rdata == 8'h00) else $error("bad miss");
    a_refuse_keep: assert property (sfr_wr && !map_addr
        |=> $stable(comp0_neg_sel) && $stable(comp0_pos_sel)
        && $stable(comp1_neg_sel) && $stable(comp1_pos_sel)) else $error("refused write landed");
    a_neg0_decode: assert property (s_wr0 |=> comp0_neg_sel ==
        ((16'h0001 << $past(sfr_wdata[7:4])) & `CIS_NEG_VALID_MASK)) else $error("neg0");
    a_pos0_decode: assert property (s_wr0 |=> comp0_pos_sel ==
        ((16'h0001 << $past(sfr_wdata[3:0])) & `CIS_POS_VALID_MASK)) else $error("pos0");
    a_neg1_decode: assert property (s_wr1 |=> comp1_neg_sel ==
        ((16'h0001 << $past(sfr_wdata[7:4])) & `CIS_NEG_VALID_MASK)) else $error("neg1");
    a_pos1_decode: assert property (s_wr1 |=> comp1_pos_sel ==
        ((16'h0001 << $past(sfr_wdata[3:0])) & `CIS_POS_VALID_MASK)) else $error("pos1");
    a_half0_track: assert property (comp0_half_div_en ==
        (comp0_neg_sel[13] || comp0_pos_sel[13])) else $error("half0");
    a_half1_track: assert property (comp1_half_div_en ==
        (comp1_neg_sel[13] || comp1_pos_sel[13])) else $error("half1");
endmodule
bind cis_input_select cis_input_select_properties u_props (.clk, .sys_rst, .sfr_page,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .comp0_neg_sel,
    .comp0_pos_sel, .comp0_half_div_en, .comp1_neg_sel, .comp1_pos_sel, .comp1_half_div_en);
`default_nettype wire

/* test/cis_input_select_test.sv */
// Self-checking bench for the comparator input selection block
`timescale 1ns/100ps
`default_nettype none
module cis_input_select_test
    import cis_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_page = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_hit, comp0_half_div_en, comp1_half_div_en;
    logic [15:0] comp0_neg_sel, comp0_pos_sel, comp1_neg_sel, comp1_pos_sel;
    int err_total = 0;
    int checks = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    cis_input_select dut (.clk, .sys_rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .sfr_hit, .comp0_neg_sel, .comp0_pos_sel, .comp0_half_div_en,
        .comp1_neg_sel, .comp1_pos_sel, .comp1_half_div_en);
    // Four-state compare, so an unknown never matches
    task automatic chk(input cis_sel_t got, input cis_sel_t exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One access, strobe held for exactly one rising edge
    task automatic acc(input logic w, input logic [7:0] pg,
        input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {sfr_page, sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {pg, a, d, w, !w};
        @(negedge clk);
        {sfr_wr, sfr_rd} = 2'b00;
    endtask
    // Reserved codes drive no mux line at all
    function automatic cis_sel_t want(input logic [3:0] c, input logic neg);
        if (neg ? (c == 4 || c == 5 || c == 11) : (c >= 4 && c <= 6)) return 16'h0000;
        return 16'h0001 << c;
    endfunction
    task automatic t_reset();
        chk(comp0_neg_sel, 16'h8000);
        chk(comp0_pos_sel, 16'h8000);
        chk(comp1_neg_sel, 16'h8000);
        chk(comp1_pos_sel, 16'h8000);
        chk({comp0_half_div_en, comp1_half_div_en}, 16'h0000);
        acc(1'b0, 8'h00, 8'h9f, 8'h00);
        chk({sfr_hit, sfr_rdata}, 16'h01ff);
        acc(1'b0, 8'h00, 8'h9e, 8'h00);
        chk({sfr_hit, sfr_rdata}, 16'h01ff);
        @(negedge clk);
        chk(sfr_hit, 16'h0000);
    endtask
    // Every code on both nibbles of both registers, read back each time
    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            acc(1'b1, 8'h00, 8'h9f, {c[3:0], c[3:0]});
            acc(1'b1, 8'h00, 8'h9e, {c[3:0], ~c[3:0]});
            chk(comp0_neg_sel, want(c[3:0], 1'b1));
            chk(comp0_pos_sel, want(c[3:0], 1'b0));
            chk(comp1_neg_sel, want(c[3:0], 1'b1));
            chk(comp1_pos_sel, want(~c[3:0], 1'b0));
            chk({comp0_half_div_en, comp1_half_div_en}, {c == 13, c == 13 || c == 2});
            acc(1'b0, 8'h00, 8'h9f, 8'h00);
            chk(sfr_rdata, {c[3:0], c[3:0]});
            acc(1'b0, 8'h00, 8'h9e, 8'h00);
            chk(sfr_rdata, {c[3:0], ~c[3:0]});
        end
    endtask
    // Wrong page or address must neither store nor answer
    task automatic t_refuse();
        acc(1'b1, 8'h01, 8'h9f, 8'h12);
        acc(1'b1, 8'h00, 8'h9d, 8'h12);
        acc(1'b0, 8'h01, 8'h9e, 8'h00);
        chk({sfr_hit, sfr_rdata}, 16'h0000);
        acc(1'b0, 8'h00, 8'h9f, 8'h00);
        chk(sfr_rdata, 16'h00ff);
        acc(1'b0, 8'h00, 8'h9e, 8'h00);
        chk(sfr_rdata, 16'h00f0);
    endtask
    task automatic end_of_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Second reset in mid-run must restore the same state
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_codes();
        t_refuse();
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
